// [sad_pkg.sv]
// constants and types shared by the single-access ram and i/o space decoder
package sad_pkg;
   // bus masters
   localparam int NUM_MASTERS = 8;
   localparam int M_CPU_PROG  = 0;
   localparam int M_CPU_DATA  = 1;
   localparam int M_DMA0      = 2;
   localparam int M_DMA3      = 5;
   localparam int M_LCD       = 6;
   localparam int M_USB       = 7;
   localparam int NUM_CPU     = 2;

   // single-access ram geometry
   localparam int NUM_BANKS   = 32;
   localparam int BANK_WORDS  = 4096;
   localparam int DATA_W      = 16;
   localparam int ADDR_W      = 32;
   localparam int BANK_LSB    = 13;
   localparam int WORD_LSB    = 1;

   // single-access ram windows, processor view and dma/usb view
   localparam logic [31:0] CPU_SA_LO  = 32'h0001_0000;
   localparam logic [31:0] CPU_SA_HI  = 32'h0004_FFFF;
   localparam logic [31:0] DMA_SA_LO  = 32'h0009_0000;
   localparam logic [31:0] DMA_SA_HI  = 32'h000C_FFFF;
   localparam logic [31:0] BOOT_LO    = 32'h0004_E000;

   // dual-access ram windows and mapped cpu registers
   localparam logic [31:0] CPU_DA_LO  = 32'h0000_0000;
   localparam logic [31:0] CPU_DA_HI  = 32'h0000_FFFF;
   localparam logic [31:0] DMA_DA_LO  = 32'h0001_0000;
   localparam logic [31:0] DMA_DA_HI  = 32'h0001_FFFF;
   localparam logic [31:0] MMR_BYTES  = 32'h0000_00C0;

   // read data after reset
   localparam logic [15:0] RDATA_RST  = 16'h0000;

   // i/o space windows, 16-bit word addresses
   typedef enum {
      IO_IDLE, IO_DMA0, IO_DMA1, IO_DMA2, IO_DMA3, IO_TMR0, IO_TMR1, IO_TMR2,
      IO_RTC, IO_I2C, IO_UART, IO_SYSCTL, IO_I2S0, IO_I2S1, IO_I2S2, IO_I2S3,
      IO_LCD, IO_SPI, IO_SD0, IO_SD1, IO_ANALOG, IO_USB, IO_NONE
   } sad_io_type;
   localparam int IO_WINDOWS = 22;
   localparam logic [15:0] IO_LO [IO_WINDOWS] = '{
      16'h0000, 16'h0C00, 16'h0D00, 16'h0E00, 16'h0F00, 16'h1800, 16'h1840,
      16'h1880, 16'h1900, 16'h1A00, 16'h1B00, 16'h1C00, 16'h2800, 16'h2900,
      16'h2A00, 16'h2B00, 16'h2E00, 16'h3000, 16'h3A00, 16'h3B00, 16'h7000,
      16'h8000};
   localparam logic [15:0] IO_HI [IO_WINDOWS] = '{
      16'h0004, 16'h0C7F, 16'h0D7F, 16'h0E7F, 16'h0F7F, 16'h181F, 16'h185F,
      16'h189F, 16'h197F, 16'h1A6C, 16'h1B1F, 16'h1CFF, 16'h2840, 16'h2940,
      16'h2A40, 16'h2B40, 16'h2E40, 16'h300F, 16'h3A7F, 16'h3B7F, 16'h70FF,
      16'hFFFF};
endpackage : sad_pkg

// [sad_bank.sv]
// one single-port bank of the single-access ram
`timescale 1ns/10ps
`default_nettype none
module sad_bank #(
   parameter int WORDS = 4096,
   parameter int WIDTH = 16
) (
   // clock
   input  wire logic                     core_clk_i,
   input  wire logic                     ce_i,
   // single access port
   input  wire logic                     en_i,
   input  wire logic                     we_i,
   input  wire logic [$clog2(WORDS)-1:0] addr_i,
   input  wire logic [WIDTH-1:0]         wdata_i,
   output logic      [WIDTH-1:0]         rdata_o
);
   logic [WIDTH-1:0] mem [WORDS];

   // one port: a read or a write per cycle, never both
   always_ff @(posedge core_clk_i) begin
      if (ce_i && en_i && we_i) begin
         mem[addr_i] <= wdata_i; // (RULE3) (RULE8)
      end
   end

   // read is combinational so the owner can register it in the grant cycle
   assign rdata_o = mem[addr_i]; // (RULE3)
endmodule : sad_bank
`default_nettype wire

// [sad_decode.sv]
// single-access ram arbiter and bank decode plus i/o space decoder
`timescale 1ns/10ps
`default_nettype none
//Behaviour
//(RULE1) cpu bytes 010000h-04FFFFh hit single-access ram
//(RULE2) 32 banks of 4K words, consecutive slices
//(RULE3) each bank does one read or write
//(RULE4) program, data and dma buses reach banks
//(RULE5) usb and lcd dma also reach banks
//(RULE6) dma view 0009_0000h-000C_FFFFh, same layout
//(RULE7) software avoids boot area during boot
//(RULE8) boot area is ordinary ram afterwards
//(RULE9) 64K-word word-addressed i/o space
//(RULE10) i/o decoded on its own port
//(RULE11) masters never touch reserved i/o words
//(RULE12) dma reaches listed peripherals' i/o registers
//(RULE13) software checks peripheral reset and clock first
//(RULE14) idle and four dma i/o windows
//(RULE15) timer, rtc, i2c, uart i/o windows
//(RULE16) sysctl, lcd, spi, sd, analog, usb windows
//(RULE17) eight masters: cpu, four dma, lcd, usb
//(RULE18) usb and lcd never reach dual-access ram
//(RULE19) dual-access ram low, first 192 bytes mapped
//(RULE20) one winner per bank, others stall
//(RULE21) different banks served together, no wait
module sad_decode
   import sad_pkg::*;
(
   // clock and reset
   input  wire logic                                       core_clk_i,
   input  wire logic                                       reset_i,
   input  wire logic                                       ce_i,
   // memory bus masters
   input  wire logic [sad_pkg::NUM_MASTERS-1:0]             req_i,
   input  wire logic [sad_pkg::NUM_MASTERS-1:0]             we_i,
   input  wire logic [sad_pkg::NUM_MASTERS-1:0][31:0]       addr_i,
   input  wire logic [sad_pkg::NUM_MASTERS-1:0][15:0]       wdata_i,
   output logic      [sad_pkg::NUM_MASTERS-1:0]             gnt_o,
   output logic      [sad_pkg::NUM_MASTERS-1:0]             rvalid_o,
   output logic      [sad_pkg::NUM_MASTERS-1:0][15:0]       rdata_o,
   output logic      [sad_pkg::NUM_MASTERS-1:0]             dual_access_ram_sel_o,
   output logic      [sad_pkg::NUM_MASTERS-1:0]             mmr_sel_o,
   output logic      [sad_pkg::NUM_MASTERS-1:0]             miss_o,
   // i/o space port
   input  wire logic                                       io_req_i,
   input  wire logic                                       io_from_dma_i,
   input  wire logic [15:0]                                io_addr_i,
   output sad_pkg::sad_io_type                             io_sel_o,
   output logic                                            io_valid_o,
   output logic                                            io_refused_o
);
   import sad_pkg::*;

   // {hit, bank, word} for a byte address in either view
   function automatic logic [17:0] sa_decode(input logic [31:0] a, input logic cpu_view);
      logic [31:0] lo;
      logic [31:0] hi;
      logic [31:0] off;
      lo  = cpu_view ? CPU_SA_LO : DMA_SA_LO;
      hi  = cpu_view ? CPU_SA_HI : DMA_SA_HI;
      off = a - lo;
      sa_decode = {(a >= lo) && (a <= hi), off[17:BANK_LSB], off[BANK_LSB-1:WORD_LSB]};
   endfunction : sa_decode

   // i/o window lookup, reserved words give IO_NONE
   function automatic sad_io_type io_decode(input logic [15:0] a);
      io_decode = IO_NONE;
      for (int w = 0; w < IO_WINDOWS; w++) begin
         if (a >= IO_LO[w] && a <= IO_HI[w]) begin
            io_decode = sad_io_type'(w);
         end
      end
   endfunction : io_decode

   logic [NUM_MASTERS-1:0]       hit;
   logic [NUM_MASTERS-1:0][4:0]  hit_bank;
   logic [NUM_MASTERS-1:0][11:0] hit_word;
   logic [NUM_BANKS-1:0]         bank_en;
   logic [NUM_BANKS-1:0][2:0]    bank_owner;
   logic [NUM_BANKS-1:0][15:0]   bank_q;
   logic [NUM_MASTERS-1:0]       rd_gnt;
   sad_io_type                   io_win;

   // per-master address decode in its own view
   for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_dec
      localparam logic CPU_VIEW = (m < NUM_CPU);
      assign {hit[m], hit_bank[m], hit_word[m]} = sa_decode(addr_i[m], CPU_VIEW); // (RULE1) (RULE2) (RULE6)
      if (m < NUM_CPU) begin : g_cpu
         assign dual_access_ram_sel_o[m] = req_i[m] && addr_i[m] <= CPU_DA_HI; // (RULE19)
         assign mmr_sel_o[m]   = req_i[m] && addr_i[m] < MMR_BYTES; // (RULE19)
      end else if (m <= M_DMA3) begin : g_dma
         assign dual_access_ram_sel_o[m] = req_i[m] && addr_i[m] >= DMA_DA_LO && addr_i[m] <= DMA_DA_HI;
         assign mmr_sel_o[m]   = 1'b0;
      end else begin : g_nodaram
         assign dual_access_ram_sel_o[m] = 1'b0; // (RULE18)
         assign mmr_sel_o[m]   = 1'b0;
      end
      assign miss_o[m] = req_i[m] && !hit[m] && !dual_access_ram_sel_o[m]; // (RULE18)
   end

   // fixed priority per bank: lower master index wins, losers simply see no grant
   always_comb begin
      gnt_o      = '0;
      bank_en    = '0;
      bank_owner = '0;
      for (int m = 0; m < NUM_MASTERS; m++) begin
         if (req_i[m] && hit[m] && !bank_en[hit_bank[m]]) begin // (RULE4) (RULE5) (RULE17)
            gnt_o[m]               = 1'b1; // (RULE20) (RULE21)
            bank_en[hit_bank[m]]    = 1'b1; // (RULE20)
            bank_owner[hit_bank[m]] = 3'(m);
         end
      end
   end

   assign rd_gnt = gnt_o & ~we_i;

   // banks, each fed by its winning master only
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      sad_bank #(
         .WORDS (BANK_WORDS),
         .WIDTH (DATA_W)
      ) u_bank (
         .core_clk_i (core_clk_i),
         .ce_i       (ce_i),
         .en_i       (bank_en[b]),
         .we_i       (we_i[bank_owner[b]]), // (RULE3)
         .addr_i     (hit_word[bank_owner[b]]),
         .wdata_i    (wdata_i[bank_owner[b]]),
         .rdata_o    (bank_q[b])
      );
   end

   // read answer one cycle after the grant
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rvalid_o <= '0;
      end else if (ce_i) begin
         rvalid_o <= rd_gnt; // (RULE21)
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rdata_o <= {NUM_MASTERS{RDATA_RST}};
      end else if (ce_i) begin
         for (int m = 0; m < NUM_MASTERS; m++) begin
            if (rd_gnt[m]) begin
               rdata_o[m] <= bank_q[hit_bank[m]]; // (RULE8)
            end
         end
      end
   end

   // i/o space: separate port, never shares a path with memory
   assign io_win = io_decode(io_addr_i); // (RULE9) (RULE10) (RULE14) (RULE15) (RULE16)

   // dma may only reach the i2c, uart, i2s, sd, usb and converter windows
   function automatic logic dma_reach(input sad_io_type w);
      unique case (w)
         IO_I2C, IO_UART, IO_I2S0, IO_I2S1, IO_I2S2, IO_I2S3,
         IO_SD0, IO_SD1, IO_USB, IO_ANALOG: dma_reach = 1'b1;
         default:                           dma_reach = 1'b0;
      endcase
   endfunction : dma_reach

   // reserved words are flagged, not trapped: keeping off them is software's job
   assign io_refused_o = io_req_i && (io_win == IO_NONE ||
                         (io_from_dma_i && !dma_reach(io_win))); // (RULE11) (RULE12)
   assign io_valid_o   = io_req_i && !io_refused_o;
   assign io_sel_o     = io_req_i ? io_win : IO_NONE; // (RULE10)

   // helper: two grants landing on one bank
   logic clash;
   always_comb begin
      clash = 1'b0;
      for (int i = 0; i < NUM_MASTERS; i++) begin
         for (int j = i + 1; j < NUM_MASTERS; j++) begin
            if (gnt_o[i] && gnt_o[j] && hit_bank[i] == hit_bank[j]) begin
               clash = 1'b1;
            end
         end
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   sequence rd_taken(int m);
      ce_i && rd_gnt[m];
   endsequence

   bank_one_winner_a: assert property (!clash) // (RULE20)
      else $error("two masters granted one bank");
   loser_stalls_a: assert property (req_i[M_USB] && req_i[M_CPU_DATA] && hit[M_USB] &&
      hit[M_CPU_DATA] && hit_bank[M_USB] == hit_bank[M_CPU_DATA] |->
      !gnt_o[M_USB] && (gnt_o[M_CPU_PROG] || gnt_o[M_CPU_DATA])) // (RULE20)
      else $error("bank contention not resolved to one grant");
   free_bank_gnt_a: assert property (req_i[M_USB] && hit[M_USB] &&
      !(|(req_i[M_USB-1:0] & hit[M_USB-1:0])) |-> gnt_o[M_USB]) // (RULE21)
      else $error("lone usb request not granted");
   read_answer_a: assert property (rd_taken(M_LCD) |=> rvalid_o[M_LCD]) // (RULE5)
      else $error("granted lcd read gave no answer");
   write_readback_a: assert property (ce_i && gnt_o[0] && we_i[0] ##1 ce_i && gnt_o[0] &&
      !we_i[0] && $stable(addr_i[0]) |=> rdata_o[0] == $past(wdata_i[0], 2)) // (RULE8)
      else $error("bank write not read back");
   cpu_window_a: assert property (hit[M_CPU_DATA] == (addr_i[M_CPU_DATA] >= CPU_SA_LO &&
      addr_i[M_CPU_DATA] <= CPU_SA_HI)) // (RULE1)
      else $error("cpu single-access window decode wrong");
   dma_last_bank_a: assert property (addr_i[M_DMA0] == DMA_SA_HI |->
      hit[M_DMA0] && hit_bank[M_DMA0] == 5'h1F && hit_word[M_DMA0] == 12'hFFF) // (RULE6) (RULE2)
      else $error("dma view top word misdecoded");
   boot_area_a: assert property (addr_i[0] == BOOT_LO |-> hit[0] && hit_bank[0] == 5'h1F) // (RULE8)
      else $error("boot area not in last bank");
   no_dual_access_ram_a: assert property (dual_access_ram_sel_o[M_USB:M_LCD] == 2'b00) // (RULE18)
      else $error("usb or lcd routed to dual-access ram");
   mmr_area_a: assert property (req_i[M_CPU_DATA] && addr_i[M_CPU_DATA] == 32'h0000_00BF |->
      mmr_sel_o[M_CPU_DATA] && dual_access_ram_sel_o[M_CPU_DATA]) // (RULE19)
      else $error("mapped register area misdecoded");
   io_dma3_a: assert property (io_req_i && io_addr_i == 16'h0F7F |->
      io_sel_o == IO_DMA3 && io_valid_o == !io_from_dma_i) // (RULE14)
      else $error("dma3 i/o window misdecoded");
   io_reserved_a: assert property (io_req_i && io_addr_i == 16'h1A6D |->
      io_refused_o && !io_valid_o) // (RULE15) (RULE11)
      else $error("reserved i/o word accepted");
   io_usb_dma_a: assert property (io_req_i && io_addr_i[15] |->
      io_sel_o == IO_USB && io_valid_o) // (RULE16) (RULE12)
      else $error("usb i/o window refused");
endmodule : sad_decode
`default_nettype wire

// [sad_usb_model.sv]
// usb internal dma master model for the bank port
`timescale 1ns/10ps
`default_nettype none
module sad_usb_model (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   // command from bench
   input  wire logic        go_i,
   input  wire logic        go_we_i,
   input  wire logic [31:0] go_addr_i,
   input  wire logic [15:0] go_wdata_i,
   // answer from decoder
   input  wire logic        gnt_i,
   input  wire logic        rvalid_i,
   input  wire logic [15:0] rdata_i,
   // request to decoder, read data and done to bench
   output logic             req_o,
   output logic             we_o,
   output logic      [31:0] addr_o,
   output logic      [15:0] wdata_o,
   output logic      [15:0] data_o,
   output logic             done_o
);
   // memory traffic only, never reserved i/o words
   always_ff @(posedge core_clk_i) begin
      done_o <= 1'b0;
      if (reset_i) begin
         req_o   <= 1'b0;
         we_o    <= 1'b0;
         addr_o  <= '0;
         wdata_o <= '0;
      end else if (go_i) begin
         req_o   <= 1'b1;
         we_o    <= go_we_i;
         addr_o  <= go_addr_i;
         wdata_o <= go_wdata_i;
      end else if (req_o && gnt_i) begin
         // held until granted; address and write data then scrambled so stale values cannot pass
         req_o   <= 1'b0;
         addr_o  <= ~addr_o;
         wdata_o <= ~wdata_o;
         done_o  <= we_o;
      end
      if (rvalid_i) begin
         data_o <= rdata_i;
         done_o <= 1'b1;
      end
   end
endmodule : sad_usb_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the single-access ram and i/o decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sad_pkg::*;
   logic             clk, rst, go, go_we, io_req, io_dma, io_valid, io_ref, ce;
   logic             u_req, u_we, u_done;
   logic [7:0]       req, we, gnt, rvalid, dsel, msel, miss;
   logic [7:0][31:0] addr;
   logic [7:0][15:0] wdata, rdata;
   logic [31:0]      go_addr, u_addr;
   logic [15:0]      go_wdata, u_wdata, u_data, io_addr, q;
   sad_io_type       io_sel;
   int               bad_count, check_count, cycles;
   wire [7:0]        req_w  = {u_req, req[6:0]};
   wire [7:0]        we_w   = {u_we, we[6:0]};
   wire [7:0][31:0]  addr_w = {u_addr, addr[6:0]};
   wire [7:0][15:0]  wd_w   = {u_wdata, wdata[6:0]};

   sad_decode dut (.core_clk_i(clk), .reset_i(rst), .ce_i(ce), .req_i(req_w),
      .we_i(we_w), .addr_i(addr_w), .wdata_i(wd_w), .gnt_o(gnt), .rvalid_o(rvalid),
      .rdata_o(rdata), .dual_access_ram_sel_o(dsel), .mmr_sel_o(msel), .miss_o(miss),
      .io_req_i(io_req), .io_from_dma_i(io_dma), .io_addr_i(io_addr),
      .io_sel_o(io_sel), .io_valid_o(io_valid), .io_refused_o(io_ref));
   sad_usb_model usb (.core_clk_i(clk), .reset_i(rst), .go_i(go), .go_we_i(go_we),
      .go_addr_i(go_addr), .go_wdata_i(go_wdata), .gnt_i(gnt[7]), .rvalid_i(rvalid[7]),
      .rdata_i(rdata[7]), .req_o(u_req), .we_o(u_we), .addr_o(u_addr),
      .wdata_o(u_wdata), .data_o(u_data), .done_o(u_done));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic expect_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : expect_val

   task automatic stop_test();
      if (bad_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // one master, one word; request held until its taking edge
   task automatic access(input int m, input logic w, input logic [31:0] a,
                         input logic [15:0] d);
      @(posedge clk);
      req[m]   <= 1'b1;
      we[m]    <= w;
      addr[m]  <= a;
      wdata[m] <= d;
      #1 expect_val(gnt[m], 1, "grant missing");
      @(posedge clk);
      req[m] <= 1'b0;
      #1 expect_val(rvalid[m], !w, "read valid timing");
      q = rdata[m];
   endtask : access

   task automatic usb_op(input logic w, input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      go       <= 1'b1;
      go_we    <= w;
      go_addr  <= a;
      go_wdata <= d;
      @(posedge clk);
      go <= 1'b0;
   endtask : usb_op

   task automatic usb_wait();
      for (int n = 0; n < 20 && u_done !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      expect_val(u_done, 1, "usb master not served");
   endtask : usb_wait

   task automatic t_mem();
      access(1, 1, 32'h0001_0002, 16'hA5A5);
      access(1, 1, 32'h0001_2002, 16'h1111);
      access(2, 0, 32'h0009_0002, 16'h0000);
      expect_val(q, 16'hA5A5, "dma view of bank 0");
      // boot is over once reset ends, so the boot area is free
      access(0, 1, 32'h0004_E000, 16'hB007);
      access(2, 1, 32'h000C_FFFF, 16'h4321);
      access(0, 0, 32'h0004_E000, 16'h0000);
      expect_val(q, 16'hB007, "boot area reuse");
      access(1, 0, 32'h0004_FFFE, 16'h0000);
      expect_val(q, 16'h4321, "top word of last bank");
      // write then read of one word in adjacent cycles
      @(posedge clk);
      req[0]   <= 1'b1;
      we[0]    <= 1'b1;
      addr[0]  <= 32'h0001_A004;
      wdata[0] <= 16'h7E57;
      @(posedge clk);
      we[0] <= 1'b0;
      @(posedge clk);
      req[0] <= 1'b0;
      #1 expect_val(rdata[0], 16'h7E57, "write then read next cycle");
   endtask : t_mem

   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      access(0, 1, 32'h0004_E000, 16'hDEAD);
      @(posedge clk);
      ce <= 1'b1;
      access(0, 0, 32'h0004_E000, 16'h0000);
      expect_val(q, 16'hB007, "write landed with clock enable low");
   endtask : t_freeze

   task automatic t_conflict();
      usb_op(1, 32'h0009_4010, 16'h5A5A);
      req[1]  <= 1'b1;
      we[1]   <= 1'b0;
      addr[1] <= 32'h0001_4020;
      #1 expect_val(gnt[7:6] & 2'b10 | {1'b0, gnt[1]}, 2'b01, "same bank winner");
      @(posedge clk);
      req[1] <= 1'b0;
      #1 expect_val(gnt[7], 1, "stalled master served later");
      expect_val(rvalid[1], 1, "winner read answered");
      usb_wait();
      usb_op(0, 32'h0009_4010, 16'h0000);
      usb_wait();
      expect_val(u_data, 16'h5A5A, "usb read back");
      access(1, 0, 32'h0001_4010, 16'h0000);
      expect_val(q, 16'h5A5A, "cpu view of usb word");
   endtask : t_conflict

   task automatic t_parallel();
      @(posedge clk);
      req      <= 8'h49;
      we       <= 8'h49;
      addr[0]  <= 32'h0001_6000;
      addr[3]  <= 32'h0009_E000;
      addr[6]  <= 32'h000B_8000;
      wdata[0] <= 16'h0003;
      wdata[3] <= 16'h0007;
      wdata[6] <= 16'h0014;
      #1 expect_val(gnt, 8'h49, "different banks together");
      @(posedge clk);
      req <= 8'h00;
      access(5, 0, 32'h0009_6000, 16'h0000);
      expect_val(q, 16'h0003, "program bus write");
      access(5, 0, 32'h0009_E000, 16'h0000);
      expect_val(q, 16'h0007, "dma write");
      access(6, 0, 32'h000B_8000, 16'h0000);
      expect_val(q, 16'h0014, "lcd write");
   endtask : t_parallel

   task automatic t_dual_access_ram();
      @(posedge clk);
      req     <= 8'h47;
      we      <= 8'h00;
      addr[0] <= 32'h0000_00C0;
      addr[1] <= 32'h0000_00BF;
      addr[2] <= 32'h0001_FFFE;
      addr[6] <= 32'h0001_0000;
      #1 expect_val(dsel, 8'h07, "dual ram select");
      expect_val(msel, 8'h02, "mapped register select");
      expect_val(miss, 8'h40, "lcd kept off dual ram");
      expect_val(gnt, 8'h00, "no bank grant");
      @(posedge clk);
      req <= 8'h00;
   endtask : t_dual_access_ram

   task automatic t_io();
      logic [15:0] a [16] = '{16'h0004, 16'h0C7F, 16'h0F7F, 16'h1840, 16'h197F, 16'h1A6C,
         16'h1B1F, 16'h1CFF, 16'h2E40, 16'h300F, 16'h3B7F, 16'h70FF, 16'h8000, 16'h0005,
         16'h1A6D, 16'h1800};
      sad_io_type s [16] = '{IO_IDLE, IO_DMA0, IO_DMA3, IO_TMR1, IO_RTC, IO_I2C, IO_UART,
         IO_SYSCTL, IO_LCD, IO_SPI, IO_SD1, IO_ANALOG, IO_USB, IO_NONE, IO_NONE, IO_NONE};
      logic [15:0] f = 16'h9C60;
      logic [15:0] r = 16'hE000;
      // peripherals taken as out of reset and clocked
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         io_req  <= 1'b1;
         io_addr <= a[i];
         io_dma  <= f[i];
         #1 expect_val(io_ref, r[i], "io refusal");
         expect_val(io_valid, !r[i], "io valid");
         if (!r[i]) expect_val(io_sel, s[i], "io window");
      end
      @(posedge clk);
      io_req <= 1'b0;
      #1 expect_val(io_sel, IO_NONE, "idle io port");
   endtask : t_io

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      {req, we, addr, wdata, go, go_we, go_addr, go_wdata, io_req, io_dma, io_addr} = '0;
      ce  = 1'b1;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_mem();
      t_freeze();
      t_conflict();
      t_parallel();
      t_dual_access_ram();
      t_io();
      stop_test();
   end
endmodule : tb
`default_nettype wire
